/* File: rtl/autoneg_ident_register_bank.v */
// identifier and negotiation register bank behind an axi4-lite slave.
// assumes the negotiation engine pulses page and fault events on aclk.
//
// Contract
// - id register one carries identifier bits 3-18
// - id two: identifier, model, revision fields
// - revision reset comes from silicon revision input
// - advertised next page stored, never enables exchange
// - writable local remote fault, resets zero
// - writable asymmetric and symmetric pause bits
// - pause reset from pause strap level
// - speed advertise bits reset from mode straps
// - selector resets to 802.3 code, writable
// - partner base page captured, resets to the 802.3 selector code (0x0001)
// - partner four-pair bit always reads zero
// - acknowledge bit set once partner word received
// - parallel detection fault latches high
// - page received latches high
// - partner negotiation and next page flags
// - local next page able reads zero
// - next page, message, ack2 writable; message resets one
// - toggle reads inverse of previous page toggle
// - message code field writable, resets to one
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "an_regs_map.vh"
module autoneg_ident_register_bank (
  input  wire        aclk,             // bank clock, 100 MHz
  input  wire        aresetn,          // synchronous reset, active low
  // axi4-lite write address
  input  wire [5:0]  s_axi_awaddr,     // byte address
  input  wire        s_axi_awvalid,    // address valid
  output wire        s_axi_awready,    // address taken
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,      // write data
  input  wire [3:0]  s_axi_wstrb,      // byte enables
  input  wire        s_axi_wvalid,     // data valid
  output wire        s_axi_wready,     // data taken
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,      // write answer
  output reg         s_axi_bvalid,     // answer valid
  input  wire        s_axi_bready,     // answer taken
  // axi4-lite read address
  input  wire [5:0]  s_axi_araddr,     // byte address
  input  wire        s_axi_arvalid,    // address valid
  output wire        s_axi_arready,    // address taken
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,      // read data
  output reg  [1:0]  s_axi_rresp,      // read answer
  output reg         s_axi_rvalid,     // data valid
  input  wire        s_axi_rready,     // data taken
  // straps and silicon revision
  input  wire        pause_default_strap, // pause advertise default
  input  wire [3:0]  mode_strap,       // speed advertise defaults
  input  wire [3:0]  silicon_revision, // revision field default
  // negotiation engine side
  input  wire        partner_page_valid, // one-cycle: base page arrived
  input  wire [15:0] partner_page,     // received base page word
  input  wire        partner_an_able,  // level: partner negotiates
  input  wire        pd_fault_event,   // one-cycle: parallel detect fault
  input  wire        page_sent,        // one-cycle: next page sent
  output wire [15:0] advertise_word,   // base page to transmit
  output wire [15:0] next_page_word,   // next page to transmit
  output wire        next_page_enable  // next page exchange enabled
);

  ////////////////////////////////////////////////////////////////////
  // storage
  reg  [15:0] ident_upper;     // identifier register one
  reg  [15:0] ident_lower;     // identifier register two
  reg  [15:0] advertise;       // local advertisement
  reg  [15:0] partner;         // partner base page
  reg         partner_np;      // partner next page ability
  reg  [15:0] np_tx;           // next page transmit (toggle apart)
  reg         last_toggle;     // toggle used on previous page
  reg         straps_loaded;   // defaults from straps applied
  reg  [5:0]  wr_addr;         // held write address
  reg         wr_addr_ok;      // write address held
  reg  [31:0] wr_data;         // held write data
  reg  [3:0]  wr_strb;         // held byte enables
  reg         wr_data_ok;      // write data held
  wire [4:0]  strap_val;       // captured strap levels
  wire        strap_done;      // straps captured
  wire        pd_fault;        // latched fault flag
  wire        page_rx;         // latched page flag
  wire        rd_clear_exp;    // expansion register was read

  ////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  strap_capture u_straps (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .strap_in   ({pause_default_strap, mode_strap}),
    .strap_val  (strap_val),
    .strap_done (strap_done)
  );

  ////////////////////////////////////////////////////////////////////
  // latching-high expansion flags
  latch_high_flag u_pd_fault (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .event_in (pd_fault_event),
    .rd_clear (rd_clear_exp),
    .flag     (pd_fault)
  );

  latch_high_flag u_page_rx (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .event_in (partner_page_valid),
    .rd_clear (rd_clear_exp),
    .flag     (page_rx)
  );

  ////////////////////////////////////////////////////////////////////
  // write channel handshake: take address and data in any order
  wire wr_fire = wr_addr_ok && wr_data_ok && !s_axi_bvalid;
  wire [3:0] wr_idx = wr_addr[5:2];

  assign s_axi_awready = !wr_addr_ok;
  assign s_axi_wready  = !wr_data_ok;

  // hold address and data until both are here
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr    <= 6'h00;
      wr_addr_ok <= 1'b0;
      wr_data    <= 32'h0000_0000;
      wr_strb    <= 4'h0;
      wr_data_ok <= 1'b0;
    end else begin
      if (s_axi_awvalid && !wr_addr_ok) begin
        wr_addr    <= s_axi_awaddr;
        wr_addr_ok <= 1'b1;
      end else if (wr_fire) begin
        wr_addr_ok <= 1'b0;
      end
      if (s_axi_wvalid && !wr_data_ok) begin
        wr_data    <= s_axi_wdata;
        wr_strb    <= s_axi_wstrb;
        wr_data_ok <= 1'b1;
      end else if (wr_fire) begin
        wr_data_ok <= 1'b0;
      end
    end
  end

  // write response; unmapped index answers slverr
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (wr_idx >= `IDX_VENDOR_IDENT_UPPER &&
          wr_idx <= `IDX_NEXT_PAGE_TRANSMIT) begin
        s_axi_bresp <= `RESP_OKAY;
      end else begin
        s_axi_bresp <= `RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // byte-lane merge: only the low two lanes carry register bits
  wire [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  function [15:0] merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [15:0] wmask;
    input [15:0] lmask;
    reg   [15:0] m;
    begin
      m     = wmask & lmask;
      merge = (old_val & ~m) | (new_val & m);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // writable registers; strap defaults load once straps are caught
  always @(posedge aclk) begin
    if (!aresetn) begin
      ident_upper   <= `RST_VENDOR_UPPER;
      ident_lower   <= {`RST_VENDOR_LOW6, `RST_MODEL, 4'h0};
      advertise     <= {11'h000, `SELECTOR_8023};
      np_tx         <= `RST_NP_TRANSMIT;
      straps_loaded <= 1'b0;
    end else if (strap_done && !straps_loaded) begin
      // revision and strap-derived defaults, before any write
      straps_loaded                    <= 1'b1;
      ident_lower[3:0]                 <= silicon_revision;
      advertise[`ADV_PAUSE]            <= strap_val[4];
      advertise[`ADV_SPEED_HI:`ADV_SPEED_LO] <= strap_val[3:0];
    end else if (wr_fire) begin
      case (wr_idx)
        `IDX_VENDOR_IDENT_UPPER: begin
          ident_upper <= merge(ident_upper, wr_data[15:0],
                               16'hffff, lane_mask);
        end
        `IDX_VENDOR_IDENT_LOWER: begin
          ident_lower <= merge(ident_lower, wr_data[15:0],
                               16'hffff, lane_mask);
        end
        `IDX_LOCAL_ADVERTISE: begin
          // reserved bits 14, 12, 9 keep zero
          advertise <= merge(advertise, wr_data[15:0],
                             `ADV_WMASK, lane_mask);
        end
        `IDX_NEXT_PAGE_TRANSMIT: begin
          // toggle and reserved bits are not writable
          np_tx <= merge(np_tx, wr_data[15:0], `NP_WMASK, lane_mask);
        end
        default: begin
          // read-only or unmapped: nothing stored
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // partner page capture from the negotiation engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      partner    <= {11'h000, `SELECTOR_8023};
      partner_np <= 1'b0;
    end else if (partner_page_valid) begin
      // t4, asymmetric pause and reserved bits dropped, acknowledge forced on
      partner            <= (partner_page & `LP_MASK) |
                            (16'h0001 << `LP_ACK);
      partner_np         <= partner_page[15];
    end
  end

  // toggle tracks the page last sent; register shows its inverse
  always @(posedge aclk) begin
    if (!aresetn) begin
      last_toggle <= 1'b1;
    end else if (page_sent) begin
      last_toggle <= ~last_toggle;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register views
  wire [15:0] expansion_view = {11'h000, pd_fault, partner_np,
                                1'b0, page_rx,
                                partner_an_able};
  wire [15:0] np_view = {np_tx[15:12], ~last_toggle,
                         np_tx[10:0]};

  // the device has no next page function, so the bit stays inert
  assign next_page_enable = 1'b0;
  assign advertise_word   = advertise;
  assign next_page_word   = np_view;

  ////////////////////////////////////////////////////////////////////
  // read channel: one read at a time, data one cycle after address
  wire [3:0] rd_idx = s_axi_araddr[5:2];
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_clear_exp  = s_axi_arvalid && s_axi_arready &&
                         (rd_idx == `IDX_NEG_EXPANSION);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      case (rd_idx)
        `IDX_VENDOR_IDENT_UPPER: s_axi_rdata <= {16'h0000, ident_upper};
        `IDX_VENDOR_IDENT_LOWER: s_axi_rdata <= {16'h0000, ident_lower};
        `IDX_LOCAL_ADVERTISE:    s_axi_rdata <= {16'h0000, advertise};
        `IDX_PARTNER_ABILITY:    s_axi_rdata <= {16'h0000, partner};
        `IDX_NEG_EXPANSION:      s_axi_rdata <= {16'h0000,
                                                 expansion_view};
        `IDX_NEXT_PAGE_TRANSMIT: s_axi_rdata <= {16'h0000, np_view};
        default: begin
          // unmapped word: zero data, slave error
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // autoneg_ident_register_bank
`default_nettype wire

/* File: rtl/an_regs_map.vh */
// register indices, field positions and reset values of the
// identifier and negotiation register bank.
// assumes includers use the macros only, no code here.
`ifndef AN_REGS_MAP_VH
`define AN_REGS_MAP_VH

// register indices; byte address is four times the index
`define IDX_VENDOR_IDENT_UPPER   4'h2
`define IDX_VENDOR_IDENT_LOWER   4'h3
`define IDX_LOCAL_ADVERTISE      4'h4
`define IDX_PARTNER_ABILITY      4'h5
`define IDX_NEG_EXPANSION        4'h6
`define IDX_NEXT_PAGE_TRANSMIT   4'h7
`define ADDR_WIDTH               6

// identifier defaults (values are arbitrary, not a real maker)
`define RST_VENDOR_UPPER         16'h1234
`define RST_VENDOR_LOW6          6'h15
`define RST_MODEL                6'h2a

// advertisement fields
`define ADV_NEXT_PAGE            15
`define ADV_REMOTE_FAULT         13
`define ADV_ASYM_PAUSE           11
`define ADV_PAUSE                10
`define ADV_SPEED_HI             8
`define ADV_SPEED_LO             5
`define SELECTOR_8023            5'h01
`define ADV_WMASK                16'hadff

// partner ability fields
`define LP_ACK                   14
`define LP_T4                    9
`define LP_MASK                  16'ha5ff

// expansion fields
`define EXP_PD_FAULT             4
`define EXP_LP_NP_ABLE           3
`define EXP_NP_ABLE              2
`define EXP_PAGE_RX              1
`define EXP_LP_AN_ABLE           0

// next page transmit fields
`define NP_NEXT_PAGE             15
`define NP_MSG_PAGE              13
`define NP_ACK2                  12
`define NP_TOGGLE                11
`define NP_WMASK                 16'hb7ff
`define RST_NP_TRANSMIT          16'h2001

// axi answers
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2

`endif

/* File: rtl/latch_high_flag.v */
// one latching-high status flag.
// assumes event and read-clear strobes are one clock wide.
`timescale 1ns/1ps
`default_nettype none
module latch_high_flag (
  input  wire aclk,      // bank clock
  input  wire aresetn,   // synchronous reset, active low
  input  wire event_in,  // condition seen this cycle
  input  wire rd_clear,  // register holding this flag was read
  output reg  flag       // sticky flag
);
  ////////////////////////////////////////////////////////////////////
  // set wins over clear so a same-cycle event is not lost
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else if (event_in) begin
      flag <= 1'b1;
    end else if (rd_clear) begin
      flag <= 1'b0;
    end
  end
endmodule // latch_high_flag
`default_nettype wire

/* File: rtl/strap_capture.v */
// catches strap levels once, after reset release.
// assumes straps are steady around reset release.
`timescale 1ns/1ps
`default_nettype none
module strap_capture (
  input  wire       aclk,        // bank clock
  input  wire       aresetn,     // synchronous reset, active low
  input  wire [4:0] strap_in,    // raw strap levels
  output reg  [4:0] strap_val,   // captured levels
  output reg        strap_done   // high once captured
);
  ////////////////////////////////////////////////////////////////////
  // capture in the first clocked cycle after reset, never under reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      strap_val  <= 5'h00;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_val  <= strap_in;
      strap_done <= 1'b1;
    end
  end
endmodule // strap_capture
`default_nettype wire

/* File: verif/autoneg_bank_chk.sv */
// port assertions for the identifier and negotiation register bank.
// assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module autoneg_bank_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        page_sent,
  input wire logic        pause_default_strap,
  input wire logic [3:0]  mode_strap,
  input wire logic [15:0] advertise_word,
  input wire logic [15:0] next_page_word,
  input wire logic        next_page_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // straps land two edges after release; earlier writes would be lost
  sequence s_strap_loaded;
    ##2 advertise_word[10] == $past(pause_default_strap, 2)
      && advertise_word[8:5] == $past(mode_strap, 2);
  endsequence
  a_strap_defaults: assert property (
    $rose(aresetn) |-> s_strap_loaded)
    else $error("advertise defaults differ from straps");
  a_selector_reset: assert property (
    $rose(aresetn) |-> advertise_word[4:0] == 5'h01)
    else $error("selector reset value wrong");
  a_np_word_reset: assert property (
    $rose(aresetn) |-> next_page_word == 16'h2001)
    else $error("next page word reset value wrong");
  a_np_exchange_off: assert property (!next_page_enable)
    else $error("next page exchange enabled");
  a_adv_reserved: assert property (
    !advertise_word[14] && !advertise_word[12] && !advertise_word[9])
    else $error("reserved advertise bit set");

  ////////////////////////////////////////////////////////////////////////////
  // toggle changes only on a sent page, and then always
  a_toggle_flip: assert property (
    page_sent |=> next_page_word[11] != $past(next_page_word[11]))
    else $error("toggle did not flip");
  a_toggle_hold: assert property (
    !page_sent |=> $stable(next_page_word[11]))
    else $error("toggle moved without a page");

  ////////////////////////////////////////////////////////////////////////////
  // one read answer per taken address
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_single: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule // autoneg_bank_chk

bind autoneg_ident_register_bank autoneg_bank_chk i_autoneg_bank_chk (.*);
`default_nettype wire

/* File: verif/an_engine_model.sv */
// behavioural negotiation engine feeding the bank's link side.
// assumes tasks are called from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module an_engine_model (
  input  wire logic        aclk,
  output var  logic        partner_page_valid,
  output var  logic [15:0] partner_page,
  output var  logic        partner_an_able,
  output var  logic        pd_fault_event,
  output var  logic        page_sent
);
  // idle outputs; the page word is junk while not valid
  initial begin
    partner_page_valid = 1'b0;
    partner_page       = 16'h5a5a;
    partner_an_able    = 1'b0;
    pd_fault_event     = 1'b0;
    page_sent          = 1'b0;
  end
  // one base page, then the word is scrambled so stale data shows
  task automatic page(input logic [15:0] w, input logic able);
    @(posedge aclk);
    partner_page       <= w;
    partner_page_valid <= 1'b1;
    partner_an_able    <= able;
    @(posedge aclk);
    partner_page_valid <= 1'b0;
    partner_page       <= ~w;
  endtask
  // one-cycle fault pulse
  task automatic fault;
    @(posedge aclk);
    pd_fault_event <= 1'b1;
    @(posedge aclk);
    pd_fault_event <= 1'b0;
  endtask
  // one next page left the wire
  task automatic sent;
    @(posedge aclk);
    page_sent <= 1'b1;
    @(posedge aclk);
    page_sent <= 1'b0;
  endtask
endmodule // an_engine_model
`default_nettype wire

/* File: verif/autoneg_ident_register_bank_test.sv */
// self-checking bench: axi4-lite master tasks and register tests.
// assumes the bank answers on its own time; a watchdog cuts hangs.
`timescale 1ns/1ps
`default_nettype none
`include "an_regs_map.vh"
module autoneg_ident_register_bank_test;
  localparam logic [1:0] okay = `RESP_OKAY;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [5:0]  s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_arready;
  logic        s_axi_bvalid, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        pause_default_strap = 1'b1;
  logic [3:0]  mode_strap = 4'ha;
  logic [3:0]  silicon_revision = 4'h5;
  logic        partner_page_valid, partner_an_able;
  logic        pd_fault_event, page_sent, next_page_enable;
  logic [15:0] partner_page, advertise_word, next_page_word;
  int          error_cnt = 0;
  int          checked = 0;

  always #5 aclk = ~aclk;

  autoneg_ident_register_bank i_autoneg_ident_register_bank (.*);
  an_engine_model i_an_engine_model (
    .aclk               (aclk),
    .partner_page_valid (partner_page_valid),
    .partner_page       (partner_page),
    .partner_an_able    (partner_an_able),
    .pd_fault_event     (pd_fault_event),
    .page_sent          (page_sent)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ready is sampled at the falling edge so the rising edge has no race
  task automatic wr(input logic [3:0] idx, input logic [15:0] d,
                    input logic [1:0] er);
    logic a, w, b;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      a = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(r, er);
  endtask
  // data is only judged when an okay answer is expected
  task automatic rd(input logic [3:0] idx, input logic [15:0] exp,
                    input logic [1:0] er);
    logic a, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge aclk);
      a = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(r, er);
    if (er === okay) chk(d, {16'h0, exp});
  endtask
  // verdict
  task automatic summarize;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(`IDX_VENDOR_IDENT_UPPER, `RST_VENDOR_UPPER, okay);
    rd(`IDX_VENDOR_IDENT_LOWER, {`RST_VENDOR_LOW6, `RST_MODEL, 4'h5},
       okay);
    rd(`IDX_LOCAL_ADVERTISE, 16'h0541, okay);
    rd(`IDX_PARTNER_ABILITY, 16'h0001, okay);
    rd(`IDX_NEG_EXPANSION, 16'h0000, okay);
    rd(`IDX_NEXT_PAGE_TRANSMIT, 16'h2001, okay);
    wr(`IDX_VENDOR_IDENT_UPPER, 16'hbeef, okay);
    rd(`IDX_VENDOR_IDENT_UPPER, 16'hbeef, okay);
    wr(`IDX_LOCAL_ADVERTISE, 16'hffff, okay);
    rd(`IDX_LOCAL_ADVERTISE, 16'hadff, okay);
    chk(advertise_word, 16'hadff);
    chk(next_page_enable, 1'b0);
    wr(`IDX_LOCAL_ADVERTISE, 16'h0000, okay);
    rd(`IDX_LOCAL_ADVERTISE, 16'h0000, okay);
    wr(`IDX_NEXT_PAGE_TRANSMIT, 16'hffff, okay);
    rd(`IDX_NEXT_PAGE_TRANSMIT, 16'hb7ff, okay);
    i_an_engine_model.sent();
    rd(`IDX_NEXT_PAGE_TRANSMIT, 16'hbfff, okay);
    wr(`IDX_PARTNER_ABILITY, 16'h1234, okay);
    rd(`IDX_PARTNER_ABILITY, 16'h0001, okay);
    i_an_engine_model.page(16'hffff, 1'b1);
    rd(`IDX_PARTNER_ABILITY, 16'he5ff, okay);
    rd(`IDX_NEG_EXPANSION, 16'h000b, okay);
    rd(`IDX_NEG_EXPANSION, 16'h0009, okay);
    i_an_engine_model.fault();
    rd(`IDX_NEG_EXPANSION, 16'h0019, okay);
    rd(`IDX_NEG_EXPANSION, 16'h0009, okay);
    rd(4'h0, 16'h0000, `RESP_SLVERR);
    wr(4'h9, 16'h0000, `RESP_SLVERR);
    summarize();
  end
  // a stuck handshake ends the run as a mismatch
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    summarize();
  end
endmodule // autoneg_ident_register_bank_test
`default_nettype wire
